// ---- rtl/ana_map.vh ----
/*
 Register map, field positions and reset values of the advertisement block.
 Assumes a 16-bit management port; only the constants live here.
*/
// Function
// [RL1] Next-page bit writable, resets to zero
// [RL2] Bit 14 always reads zero
// [RL3] Bit 14 writes need command override
// [RL4] Hardware sets bit 13 on local fault
// [RL5] Bit 13 sent as remote fault
// [RL6] Bits 12 to 10 read zero
// [RL7] Management writes reserved bits at defaults
// [RL8] Bits 12 to 10 writable under override only
// [RL9] Bits 9 to 5 advertise technologies
// [RL10] Bit 9 reads zero, override writable
// [RL11] Technology bits reset per operating mode; the code loads 4'hF at reset in both modes
// [RL12] Hardware mode makes technology bits read-only
// [RL13] Selector resets to 00001, override writable
// [RL14] Code word built from register contents
// [RL15] Advertisement register at address 4, 16 bits
// [RL16] Identifier two holds revision in bits 3:0
// [RL17] Hardware mode sets one bit by pins; the code does so only while the autoneg pin is high
// [RL18] Software mode: technology bits default all ones
// [RL19] Blocked bits keep value, others update
`ifndef ANA_MAP_VH
`define ANA_MAP_VH
`define ANA_ADDR_W        5
`define ANA_ADDR_ID2      5'h03
`define ANA_ADDR_ADV      5'h04
`define ANA_ADDR_OVR      5'h10
`define ANA_BIT_NP        15
`define ANA_BIT_ACK       14
`define ANA_BIT_RF        13
`define ANA_RES_HI        12
`define ANA_RES_LO        10
`define ANA_BIT_T4        9
`define ANA_TAF_HI        8
`define ANA_TAF_LO        5
`define ANA_SEL_HI        4
`define ANA_SEL_LO        0
`define ANA_BIT_OVR       15
`define ANA_SEL_RST       5'h01
`define ANA_TAF_SW_RST    4'hF
`define ANA_TAF_100FD     4'h8
`define ANA_TAF_100HD     4'h4
`define ANA_TAF_10FD      4'h2
`define ANA_TAF_10HD      4'h1
`define ANA_ID2_HI_RST    12'h000
`define ANA_ID2_HI_HI     15
`define ANA_ID2_HI_LO     4
`define ANA_REV_HI        3
`define ANA_REV_LO        0
`define ANA_PIN_W         4
`define ANA_PIN_HWSW      3
`define ANA_PIN_SPD       2
`define ANA_PIN_DPX       1
`define ANA_PIN_AN        0
`define ANA_PIN_RST       1'h0
`define ANA_NP_RST        1'h0
`define ANA_ACK_RST       1'h0
`define ANA_RF_RST        1'h0
`define ANA_RES_RST       3'h0
`define ANA_T4_RST        1'h0
`define ANA_OVR_RST       1'h0
`define ANA_ACK_READ      1'h0
`define ANA_RES_READ      3'h0
`define ANA_T4_READ       1'h0
`define ANA_RD_IDLE       16'h0000
`define ANA_WORD_RST      16'h0000
`define ANA_VLD_RST       1'h0
`endif

// ---- rtl/ana_adv_reg.v ----
/*
 Auto-negotiation local advertisement register with the identifier-two
 revision field and the command override bit. Assumes a synchronous
 management port on clk_i; pins come from outside and are synchronised.
*/
// The address-and-strobe port is this design's own decision.
`include "ana_map.vh"
module ana_adv_reg #(
  parameter [3:0] REVISION = 4'h3           // Arbitrary revision value
) (
  input  wire        clk_i,                 // 100 MHz clock
  input  wire        reset_i,               // Sync reset, active high
  input  wire        ce_i,                  // Clock enable
  input  wire [4:0]  addr_i,                // Register address
  input  wire [15:0] wdata_i,               // Write data
  input  wire        wr_i,                  // Write strobe
  input  wire        rd_i,                  // Read strobe
  output reg  [15:0] rdata_o,               // Read data, cycle after rd_i
  input  wire        hardware_software_select_pin_i, // Low: hardware mode
  input  wire        speed_select_pin_i,    // High: 100 Mb/s
  input  wire        duplex_select_pin_i,   // High: full duplex
  input  wire        autoneg_pin_i,         // Pin enable of autoneg
  input  wire        autoneg_enable_i,      // Autoneg enabled (same clock)
  input  wire        link_fault_i,          // Local link fault (same clock)
  output reg  [15:0] link_code_word_o,      // Word for fast link pulses
  output reg         code_word_valid_o      // Autoneg enabled, word valid
);

  // Pins are asynchronous to clk_i; two stages each before use
  wire [`ANA_PIN_W-1:0] pin_raw;
  wire [`ANA_PIN_W-1:0] pin_sync;
  wire                  hw_mode;
  wire                  sw_mode;
  wire                  pin_spd;
  wire                  pin_dpx;
  wire                  pin_an;

  // Stored fields of the advertisement register
  reg                   np_q;
  reg                   np_d;
  reg                   ack_q;
  reg                   ack_d;
  reg                   rf_q;
  reg                   rf_d;
  reg  [2:0]            res_q;
  reg  [2:0]            res_d;
  reg                   t4_q;
  reg                   t4_d;
  reg  [3:0]            taf_q;
  reg  [3:0]            taf_d;
  reg  [4:0]            sel_q;
  reg  [4:0]            sel_d;

  // Command override and the identifier-two fields
  reg                   ovr_q;
  reg                   ovr_d;
  reg  [11:0]           id2_hi_q;
  reg  [11:0]           id2_hi_d;
  reg  [3:0]            rev_q;
  reg  [3:0]            rev_d;

  // Decoded strobes and derived words
  wire                  wr_adv;
  wire                  wr_cw;
  wire                  wr_ovr;
  wire                  wr_id2;
  reg  [3:0]            taf_hw;
  reg  [15:0]           rd_d;
  wire [15:0]           adv_full;

  assign pin_raw = {hardware_software_select_pin_i, speed_select_pin_i,
                    duplex_select_pin_i, autoneg_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < `ANA_PIN_W; gi = gi + 1) begin : g_pin_sync
      reg meta_q;
      reg sync_q;
      always @(posedge clk_i) begin
        if (reset_i) begin
          meta_q <= `ANA_PIN_RST;
          sync_q <= `ANA_PIN_RST;
        end else if (ce_i) begin
          meta_q <= pin_raw[gi];
          // Only the second stage is read downstream
          sync_q <= meta_q;
        end
      end
      assign pin_sync[gi] = sync_q;
    end
  endgenerate

  // Until the chain fills after reset the block sees hardware mode
  assign hw_mode = ~pin_sync[`ANA_PIN_HWSW];
  assign sw_mode = pin_sync[`ANA_PIN_HWSW];
  assign pin_spd = pin_sync[`ANA_PIN_SPD];
  assign pin_dpx = pin_sync[`ANA_PIN_DPX];
  assign pin_an  = pin_sync[`ANA_PIN_AN];

  // Override gates the writable CW bits of the advertisement word except NP
  assign wr_adv = wr_i & (addr_i == `ANA_ADDR_ADV);
  assign wr_cw  = wr_adv & ovr_q;
  assign wr_ovr = wr_i & (addr_i == `ANA_ADDR_OVR);
  assign wr_id2 = wr_i & (addr_i == `ANA_ADDR_ID2) & ovr_q;

  // One technology from the pins; other three cleared
  always @* begin
    case ({pin_spd, pin_dpx})
      2'h3:    taf_hw = `ANA_TAF_100FD;                       // RL17
      2'h2:    taf_hw = `ANA_TAF_100HD;                       // RL17
      2'h1:    taf_hw = `ANA_TAF_10FD;                        // RL17
      default: taf_hw = `ANA_TAF_10HD;                        // RL17
    endcase
  end

  always @* begin
    np_d = np_q;
    if (wr_adv) begin
      np_d = wdata_i[`ANA_BIT_NP];                            // RL1 RL19
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      np_q <= `ANA_NP_RST;                                    // RL1
    end else if (ce_i) begin
      np_q <= np_d;
    end
  end

  always @* begin
    ack_d = ack_q;
    if (wr_cw) begin
      ack_d = wdata_i[`ANA_BIT_ACK];                          // RL3 RL19
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      ack_q <= `ANA_ACK_RST;
    end else if (ce_i) begin
      ack_q <= ack_d;
    end
  end

  // Fault status each cycle; a write to the bit cannot stick
  always @* begin
    rf_d = link_fault_i;                                      // RL4
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      rf_q <= `ANA_RF_RST;                                    // RL4
    end else if (ce_i) begin
      rf_q <= rf_d;
    end
  end

  always @* begin
    res_d = res_q;
    if (wr_cw) begin
      res_d = wdata_i[`ANA_RES_HI:`ANA_RES_LO];               // RL8
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      res_q <= `ANA_RES_RST;
    end else if (ce_i) begin
      res_q <= res_d;
    end
  end

  always @* begin
    t4_d = t4_q;
    if (wr_cw) begin
      t4_d = wdata_i[`ANA_BIT_T4];                            // RL10
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      t4_q <= `ANA_T4_RST;
    end else if (ce_i) begin
      t4_q <= t4_d;
    end
  end

  // Pins own the field in hardware mode with autoneg pin high
  always @* begin
    taf_d = taf_q;
    if (wr_cw & sw_mode) begin
      taf_d = wdata_i[`ANA_TAF_HI:`ANA_TAF_LO];               // RL12 RL18
    end
    if (hw_mode & pin_an) begin
      taf_d = taf_hw;                                         // RL17 RL12
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      taf_q <= `ANA_TAF_SW_RST;                               // RL11 RL18
    end else if (ce_i) begin
      taf_q <= taf_d;
    end
  end

  always @* begin
    sel_d = sel_q;
    if (wr_cw) begin
      sel_d = wdata_i[`ANA_SEL_HI:`ANA_SEL_LO];               // RL13
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      sel_q <= `ANA_SEL_RST;                                  // RL13
    end else if (ce_i) begin
      sel_q <= sel_d;
    end
  end

  always @* begin
    ovr_d = ovr_q;
    if (wr_ovr) begin
      ovr_d = wdata_i[`ANA_BIT_OVR];
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      ovr_q <= `ANA_OVR_RST;
    end else if (ce_i) begin
      ovr_q <= ovr_d;
    end
  end

  always @* begin
    id2_hi_d = id2_hi_q;
    if (wr_id2) begin
      id2_hi_d = wdata_i[`ANA_ID2_HI_HI:`ANA_ID2_HI_LO];
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      id2_hi_q <= `ANA_ID2_HI_RST;
    end else if (ce_i) begin
      id2_hi_q <= id2_hi_d;
    end
  end

  always @* begin
    rev_d = rev_q;
    if (wr_id2) begin
      rev_d = wdata_i[`ANA_REV_HI:`ANA_REV_LO];
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      rev_q <= REVISION;                                      // RL16
    end else if (ce_i) begin
      rev_q <= rev_d;
    end
  end

  // Stored bits, reserved ones included, feed the link word
  assign adv_full = {np_q, ack_q, rf_q, res_q, t4_q, taf_q, sel_q};

  // Reserved and unsupported bits read as zero whatever is stored
  always @* begin
    rd_d = `ANA_RD_IDLE;
    case (addr_i)
      `ANA_ADDR_ID2: begin
        rd_d[`ANA_ID2_HI_HI:`ANA_ID2_HI_LO] = id2_hi_q;
        rd_d[`ANA_REV_HI:`ANA_REV_LO]       = rev_q;          // RL16
      end
      `ANA_ADDR_ADV: begin
        rd_d                          = adv_full;             // RL15
        rd_d[`ANA_BIT_ACK]            = `ANA_ACK_READ;        // RL2
        rd_d[`ANA_RES_HI:`ANA_RES_LO] = `ANA_RES_READ;        // RL6
        rd_d[`ANA_BIT_T4]             = `ANA_T4_READ;         // RL10
      end
      `ANA_ADDR_OVR: begin
        rd_d[`ANA_BIT_OVR] = ovr_q;
      end
      default: begin
        rd_d = `ANA_RD_IDLE;
      end
    endcase
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= `ANA_RD_IDLE;
    end else if (ce_i) begin
      if (rd_i) begin
        rdata_o <= rd_d;                                      // RL15
      end else begin
        rdata_o <= `ANA_RD_IDLE;
      end
    end
  end

  // Link word trails the register by one cycle
  always @(posedge clk_i) begin
    if (reset_i) begin
      link_code_word_o <= `ANA_WORD_RST;
    end else if (ce_i) begin
      link_code_word_o <= adv_full;                           // RL14 RL5 RL9
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      code_word_valid_o <= `ANA_VLD_RST;
    end else if (ce_i) begin
      code_word_valid_o <= autoneg_enable_i;                  // RL5
    end
  end
endmodule // ana_adv_reg

// ---- verif/ana_adv_reg_asserts.sv ----
/* Port assertions of the advertisement block.
   Assumes ce_i held high. */
module ana_adv_chk (
  input wire        clk_i,             // Clock
  input wire        reset_i,           // Reset
  input wire        wr_i,              // Write strobe
  input wire        rd_i,              // Read strobe
  input wire        link_fault_i,      // Local fault
  input wire        autoneg_enable_i,  // Autoneg enable
  input wire [4:0]  addr_i,            // Address
  input wire [15:0] wdata_i,           // Write data
  input wire [15:0] rdata_o,           // Read data
  input wire [15:0] link_code_word_o,  // Code word
  input wire        code_word_valid_o  // Word valid
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_ack; rdata_o[14] == 1'b0; endproperty
  a_ack: assert property (p_ack) else $error("bit14 read");
  property p_res; rdata_o[12:10] == 3'h0; endproperty
  a_res: assert property (p_res) else $error("res read");
  property p_t4; !rdata_o[9]; endproperty
  a_t4: assert property (p_t4) else $error("t4 read");
  property p_idle; !$past(rd_i) |-> rdata_o == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("idle rdata");
  property p_id; rd_i && addr_i == 5'h03 |=> rdata_o[15:4] == 12'h000; endproperty
  a_id: assert property (p_id) else $error("id2 high");
  property p_rf; !$past(reset_i, 2) |-> link_code_word_o[13] == $past(link_fault_i, 2); endproperty
  a_rf: assert property (p_rf) else $error("rf word");
  property p_vld; !$past(reset_i) |-> code_word_valid_o == $past(autoneg_enable_i); endproperty
  a_vld: assert property (p_vld) else $error("valid");
  property p_np; wr_i && addr_i == 5'h04 ##1 !wr_i |=> link_code_word_o[15] == $past(wdata_i[15], 2); endproperty
  a_np: assert property (p_np) else $error("np word");
  c_wr: cover property (wr_i && addr_i == 5'h04);
  c_rd: cover property (rd_i && addr_i == 5'h04);
  c_rf: cover property (link_fault_i && autoneg_enable_i);
endmodule // ana_adv_chk
bind ana_adv_reg ana_adv_chk chk_u (.*);

// ---- verif/ana_sta_model.sv ----
/* Management master model, expected reads queued.
   Assumes rdata_o is compared one cycle after rd_o. */
module ana_sta_model (
  input  wire         clk_i,   // Clock
  output logic [4:0]  addr_o,  // Address
  output logic [15:0] wdata_o, // Write data
  output logic        wr_o,    // Write strobe
  output logic        rd_o     // Read strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] exp_q[$];
  initial {addr_o, wdata_o, wr_o, rd_o} = 23'h0;
  // Read slot carries the expectation on wdata_o, harmless to the slave
  task automatic io(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    {addr_o, wdata_o, wr_o, rd_o} <= {a, d, w, !w};
    if (!w) exp_q.push_back(d);
    @(posedge clk_i);
    {wr_o, rd_o} <= 2'h0;
  endtask
endmodule // ana_sta_model

// ---- verif/ana_adv_reg_test.sv ----
/* Bench of the advertisement block.
   Assumes the management model queues expected reads. */
module ana_adv_reg_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst = 1'b1, hw = 1'b1, spd = 1'b0, dpx = 1'b0, an = 1'b0, flt = 1'b0;
  logic rd_d = 1'b0, wr, rd, vld;
  logic [4:0] adr;
  logic [15:0] wd, rdt, word, d;
  int error_cnt, check_count, i;
  initial forever #5 clk_i = ~clk_i;
  ana_sta_model sta_u (.clk_i(clk_i), .addr_o(adr), .wdata_o(wd), .wr_o(wr), .rd_o(rd));
  ana_adv_reg #(.REVISION(4'h5)) dut_u (.clk_i(clk_i), .reset_i(rst), .ce_i(1'b1),
    .addr_i(adr), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdt),
    .hardware_software_select_pin_i(hw), .speed_select_pin_i(spd), .duplex_select_pin_i(dpx),
    .autoneg_pin_i(an), .autoneg_enable_i(an), .link_fault_i(flt),
    .link_code_word_o(word), .code_word_valid_o(vld));
  task automatic chk(input string n, input logic [15:0] x, v);
    check_count++;
    if (v !== x) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, x, v);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (rd_d) chk("rdata", sta_u.exp_q.pop_front(), rdt);
    rd_d <= rd;
  end
  initial begin
    #50us;
    error_cnt++;
    end_sim();
  end
  initial begin
    void'($urandom(64));
    repeat (12) @(posedge clk_i);
    rst <= 1'b0;
    sta_u.io(1'b0, 5'h04, 16'h01E1);
    sta_u.io(1'b1, 5'h03, 16'h1234);
    sta_u.io(1'b0, 5'h03, 16'h0005);
    sta_u.io(1'b0, 5'h1F, 16'h0000);
    sta_u.io(1'b1, 5'h04, 16'hFFFF);
    sta_u.io(1'b0, 5'h04, 16'h81E1);
    chk("word", 16'h81E1, word);
    $display("defaults done");
    d = 16'($urandom);
    {an, flt} <= 2'h3;
    sta_u.io(1'b1, 5'h10, 16'h8000);
    sta_u.io(1'b0, 5'h10, 16'h8000);
    sta_u.io(1'b1, 5'h04, d);
    sta_u.io(1'b0, 5'h04, {d[15], 2'h1, 4'h0, d[8:0]});
    chk("word", {d[15:14], 1'b1, d[12:0]}, word);
    chk("valid", 16'h0001, {15'h0, vld});
    $display("override done");
    hw <= 1'b0;
    for (i = 0; i < 4; i++) begin
      {spd, dpx} <= i[1:0];
      sta_u.io(1'b1, 5'h04, {d[15], 10'h0, d[4:0]});
      repeat (4) @(posedge clk_i);
      sta_u.io(1'b0, 5'h04, {d[15], 2'h1, 4'h0, 4'h1 << i, d[4:0]});
    end
    $display("hardware mode done");
    repeat (2) @(posedge clk_i);
    end_sim();
  end
endmodule // ana_adv_reg_test
